// ==== design/srb_map.svh ====
// Constants of the burst-of-two synchronous SRAM pin bus.
// Assumes one system clock; included by bare name where needed.
`ifndef SRB_MAP_SVH
`define SRB_MAP_SVH

`define SRB_DATA_W         18
`define SRB_ADDR_W         20
`define SRB_LANES          2
`define SRB_LANE_W         9
`define SRB_ARRAY_DEPTH    1048576
`define SRB_BURST_LEN      2
`define SRB_RD2WR_IDLE     2'h2
`define SRB_CLK_MHZ        25
`define SRB_LEGACY_MAX_MHZ 167
`define SRB_SEL_NONE       2'h3

`endif

// ==== design/srb_pkg.sv ====
// Types shared by both ends of the SRAM pin bus.
// Assumes srb_map.svh is on the include path.
`include "srb_map.svh"

package srb_pkg;
	typedef logic [`SRB_DATA_W-1:0] srb_word_t;
	typedef logic [`SRB_ADDR_W-1:0] srb_addr_t;
	typedef logic [`SRB_LANES-1:0]  srb_lane_t;
	typedef logic [1:0]             srb_gap_t;
endpackage

// ==== design/srb_bus_if.sv ====
// Pin bus between the memory controller and the burst-of-two SRAM.
// Assumes both ends run on the same system clock; no clocking block.
`include "srb_map.svh"

interface srb_bus_if;
	import srb_pkg::*;

	logic      k_clock;                  // Positive input clock phase
	logic      k_clock_n;                // Negative input clock phase
	logic      load_strobe_n;            // Starts a transaction, active low
	logic      read_write;               // High read, low write
	srb_addr_t addr;                     // Shared address bus
	srb_lane_t byte_lane_write_select_n; // Lane write selects, active low
	srb_word_t ctl_dq_out;               // Controller data drive
	logic      ctl_dq_oe;                // Controller drives data pins
	srb_word_t dev_dq_out;               // Device data drive
	logic      dev_dq_oe;                // Device drives data pins
	srb_word_t dq;                       // Resolved shared data pins
	logic      output_valid_flag;        // Read data present
	logic      echo_clock;               // Echo clock
	logic      echo_clock_n;             // Complementary echo clock

	// Undriven pins read as zero rather than floating
	assign dq = dev_dq_oe ? dev_dq_out : (ctl_dq_oe ? ctl_dq_out : '0);

	modport device (
		input  k_clock, k_clock_n, load_strobe_n, read_write, addr,
		input  byte_lane_write_select_n, dq,
		output dev_dq_out, dev_dq_oe, output_valid_flag, echo_clock, echo_clock_n
	);

	modport controller (
		output k_clock, k_clock_n, load_strobe_n, read_write, addr,
		output byte_lane_write_select_n, ctl_dq_out, ctl_dq_oe,
		input  dq, output_valid_flag, echo_clock, echo_clock_n
	);
endinterface

// ==== design/srb_sram_ctl.sv ====
// Memory controller end of the burst-of-two SRAM pin bus.
// Assumes the device shares clk_sys; user requests follow req_ready.
`include "srb_map.svh"

module srb_sram_ctl
	import srb_pkg::*;
(
	input  wire logic       clk_sys,     // System clock
	input  wire logic       rst,         // Synchronous reset, active high
	input  wire logic       req_valid,   // Request present
	input  wire logic       req_write,   // High write, low read
	input  wire srb_addr_t  req_addr,    // Burst address
	input  wire srb_word_t  req_wdata0,  // First write word
	input  wire srb_word_t  req_wdata1,  // Second write word
	input  wire srb_lane_t  req_sel_n0,  // First word lane selects, active low
	input  wire srb_lane_t  req_sel_n1,  // Second word lane selects, active low
	output logic            req_ready,   // Issue slot open
	output logic            wr_blocked,  // Writes held off after a read
	output srb_word_t       rd_data0,    // First read word
	output srb_word_t       rd_data1,    // Second read word
	output logic            rd_valid,    // Read burst complete, one cycle
	srb_bus_if.controller   bus          // Pin bus to the device
);
	logic      k_clock;
	logic      load_strobe_n;
	logic      read_write;
	srb_addr_t addr;
	logic [2:0] wr_stage;
	srb_word_t b1_d;
	srb_lane_t b1_m;
	srb_word_t b2_d;
	srb_lane_t b2_m;
	srb_word_t b2h_d;
	srb_lane_t b2h_m;
	srb_word_t dq_out;
	logic      dq_oe;
	srb_lane_t sel_n;
	srb_gap_t  gap;
	logic      got_first;

	// Slot is the edge that opens a positive-phase cycle
	wire logic      slot        = ~k_clock;
	wire logic      take        = slot & req_valid & req_ready & ~(req_write & wr_blocked);
	wire srb_gap_t  next_gap    = !slot ? gap :
		(take & ~req_write) ? `SRB_RD2WR_IDLE :               // [R21]
		(gap != 2'h0) ? gap - 2'h1 : 2'h0;
	wire logic [2:0] next_wr_stage = {wr_stage[1:0], take & req_write};
	wire srb_word_t next_dq_out = wr_stage[1] ? b1_d : (wr_stage[2] ? b2h_d : dq_out);   // [R1] [R20]
	wire srb_lane_t next_sel_n  = wr_stage[1] ? b1_m : (wr_stage[2] ? b2h_m : `SRB_SEL_NONE); // [R9]
	wire logic      vld         = bus.output_valid_flag;

	assign bus.k_clock                  = k_clock;
	assign bus.k_clock_n                = ~k_clock;
	assign bus.load_strobe_n            = load_strobe_n;
	assign bus.read_write               = read_write;
	assign bus.addr                     = addr;
	assign bus.byte_lane_write_select_n = sel_n;
	assign bus.ctl_dq_out               = dq_out;
	assign bus.ctl_dq_oe                = dq_oe;

	// At 25 MHz the legacy-mode ceiling is always met
	localparam bit LEGACY_OK = `SRB_CLK_MHZ <= `SRB_LEGACY_MAX_MHZ; // [R18]

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			k_clock       <= 1'b0;
			load_strobe_n <= 1'b1;
			read_write    <= 1'b1;
			addr          <= '0;
			wr_stage      <= 3'h0;
			dq_out        <= '0;
			dq_oe         <= 1'b0;
			sel_n         <= `SRB_SEL_NONE;
			gap           <= 2'h0;
			req_ready     <= 1'b0;
			wr_blocked    <= 1'b0;
			got_first     <= 1'b0;
			rd_data0      <= '0;
			rd_data1      <= '0;
			rd_valid      <= 1'b0;
		end else begin
			k_clock       <= ~k_clock;
			req_ready     <= k_clock && LEGACY_OK;
			load_strobe_n <= ~take;                              // [R4]
			read_write    <= take ? ~req_write : read_write;     // [R8]
			addr          <= take ? req_addr : addr;             // [R6] [R7]
			wr_stage      <= next_wr_stage;
			dq_out        <= next_dq_out;
			dq_oe         <= wr_stage[1] | wr_stage[2];
			sel_n         <= next_sel_n;
			gap           <= next_gap;
			wr_blocked    <= next_gap != 2'h0;
			got_first     <= vld ? ~got_first : got_first;
			rd_data0      <= (vld & ~got_first) ? bus.dq : rd_data0;
			rd_data1      <= (vld & got_first) ? bus.dq : rd_data1;
			rd_valid      <= vld & got_first;
		end
	end

	// Write words are parked so a following write can load new ones
	always_ff @(posedge clk_sys) begin
		b1_d  <= take ? req_wdata0 : b1_d;
		b1_m  <= take ? req_sel_n0 : b1_m;
		b2_d  <= take ? req_wdata1 : b2_d;
		b2_m  <= take ? req_sel_n1 : b2_m;
		b2h_d <= wr_stage[1] ? b2_d : b2h_d;
		b2h_m <= wr_stage[1] ? b2_m : b2h_m;
	end
endmodule

// ==== design/srb_sram_dev.sv ====
// Device end of the burst-of-two double-data-rate SRAM pin bus.
// Assumes the controller drives the clock phases and keeps idle gaps.
//
// What the pin bus requires
// R1: Write data sampled on both clock phases
// R2: Read drives one word per clock phase
// R3: Data drivers released when no read
// R4: Low load strobe defines new transaction
// R5: Each transaction moves exactly two words
// R6: Address sampled only at positive loads
// R7: One address bus serves reads and writes
// R8: Select high reads, low writes
// R9: Lane selects sampled with each data beat
// R10: Each select covers one nine-bit lane
// R11: Deselected lanes keep stored contents
// R12: Storage split into two equal arrays
// R13: Valid flag marks read data, echo-aligned
// R14: Accesses start at positive clock rise
// R15: Negative rise handles second beat
// R16: Echo clocks run free, follow positive clock
// R17: Disable pin low switches output timing
// R18: Legacy mode limits clock to 167 MHz
// R19: First read word two positive edges later
// R20: Controller sends write beats next edges
// R21: Controller idles two cycles read to write
// R22: Read after write returns newest data
// R23: Strobe high starts nothing, bursts finish
`include "srb_map.svh"

module srb_sram_dev
	import srb_pkg::*;
(
	input  wire logic clk_sys,       // System clock
	input  wire logic rst,           // Synchronous reset, active high
	input  wire logic dll_disable_n, // Low selects legacy timing
	output logic      legacy_mode,   // Legacy timing in force
	srb_bus_if.device bus            // Pin bus to the controller
);
	// One array per burst word
	srb_word_t mem_even [`SRB_ARRAY_DEPTH];          // [R12]
	srb_word_t mem_odd  [`SRB_ARRAY_DEPTH];

	// Load stage
	srb_addr_t ld_addr;
	logic      rd_v1;
	logic      wr_v1;

	// Read stage two positive edges on
	logic      rd_v2;
	srb_addr_t rd_a2;

	// First write beat held for the second
	logic      wc_v;
	srb_addr_t wc_a;
	srb_word_t wc_d0;
	srb_lane_t wc_m0;

	// Posted write awaiting the array
	logic      pend_v;
	srb_addr_t pend_a;
	srb_word_t pend_d0;
	srb_lane_t pend_m0;
	srb_word_t pend_d1;
	srb_lane_t pend_m1;

	// Output side
	logic      second_v;
	srb_word_t second_d;
	srb_word_t dq_out;
	logic      dq_oe;
	logic      valid;
	logic      echo;
	logic      echo_n;

	// Deselected lanes keep the old bits
	function automatic srb_word_t lane_merge(
		input srb_word_t old_w,
		input srb_word_t new_w,
		input srb_lane_t sel_n
	);
		srb_word_t res;
		res = old_w;
		for (int i = 0; i < `SRB_LANES; i++) begin
			if (!sel_n[i]) begin                              // [R11]
				res[i*`SRB_LANE_W +: `SRB_LANE_W] = new_w[i*`SRB_LANE_W +: `SRB_LANE_W]; // [R10]
			end
		end
		return res;
	endfunction

	// Edge classes: each clk_sys edge is either a positive or negative rise
	wire logic k_rise  = bus.k_clock;
	wire logic k_nrise = bus.k_clock_n;

	// Control and address are only looked at on positive rises
	wire logic load     = k_rise & ~bus.load_strobe_n;     // [R4] [R14] [R23]
	wire logic rd_load  = load & bus.read_write;           // [R8]
	wire logic wr_load  = load & ~bus.read_write;

	wire logic next_rd_v1 = k_rise ? rd_load : rd_v1;
	wire logic next_wr_v1 = k_rise ? wr_load : wr_v1;
	wire srb_addr_t next_ld_addr = load ? bus.addr : ld_addr; // [R6] [R7]
	wire logic next_rd_v2 = k_rise ? rd_v1 : rd_v2;
	wire srb_addr_t next_rd_a2 = (k_rise & rd_v1) ? ld_addr : rd_a2;

	// Write beats: first on the next positive rise, second on the negative
	wire logic beat1 = k_rise & wr_v1;                     // [R1] [R9]
	wire logic beat2 = k_nrise & wc_v;                     // [R15] [R9]
	wire logic commit = k_rise & pend_v;

	wire logic next_wc_v = beat1 ? 1'b1 : (beat2 ? 1'b0 : wc_v);
	wire logic next_pend_v = beat2 ? 1'b1 : (commit ? 1'b0 : pend_v);

	// Newest write wins over the array while it is still posted
	wire logic      fwd   = pend_v & (pend_a == rd_a2);    // [R22]
	wire srb_word_t arr0  = mem_even[rd_a2];
	wire srb_word_t arr1  = mem_odd[rd_a2];
	wire srb_word_t word0 = fwd ? lane_merge(arr0, pend_d0, pend_m0) : arr0;
	wire srb_word_t word1 = fwd ? lane_merge(arr1, pend_d1, pend_m1) : arr1;

	// Legacy timing launches half a cycle earlier
	wire logic launch = rd_v2 & (legacy_mode ? k_nrise : k_rise); // [R17] [R19]

	// Every burst is exactly two words; outputs release once it ends
	wire srb_word_t next_dq_out = launch ? word0 : (second_v ? second_d : dq_out); // [R2] [R5] [R15]
	wire logic next_active = launch | second_v;             // [R3] [R13]

	assign bus.dev_dq_out        = dq_out;
	assign bus.dev_dq_oe         = dq_oe;
	assign bus.output_valid_flag = valid;
	assign bus.echo_clock        = echo;
	assign bus.echo_clock_n      = echo_n;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_v1    <= 1'b0;
			wr_v1    <= 1'b0;
			rd_v2    <= 1'b0;
			wc_v     <= 1'b0;
			pend_v   <= 1'b0;
			second_v <= 1'b0;
			dq_oe    <= 1'b0;
			valid    <= 1'b0;
		end else begin
			rd_v1    <= next_rd_v1;
			wr_v1    <= next_wr_v1;
			rd_v2    <= next_rd_v2;
			wc_v     <= next_wc_v;
			pend_v   <= next_pend_v;
			second_v <= launch;                             // [R5]
			dq_oe    <= next_active;                        // [R3]
			valid    <= next_active;                        // [R13]
		end
	end

	// Echo clocks follow the positive phase and run whenever out of reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			echo        <= 1'b0;
			echo_n      <= 1'b1;
			legacy_mode <= 1'b0;
		end else begin
			echo        <= bus.k_clock;                     // [R16]
			echo_n      <= ~bus.k_clock;                    // [R16]
			legacy_mode <= ~dll_disable_n;                  // [R17] [R18]
		end
	end

	// Data path needs no reset; valid bits guard every use
	always_ff @(posedge clk_sys) begin
		ld_addr  <= next_ld_addr;
		rd_a2    <= next_rd_a2;
		dq_out   <= next_dq_out;
		second_d <= launch ? word1 : second_d;
	end

	always_ff @(posedge clk_sys) begin
		wc_a  <= beat1 ? ld_addr : wc_a;
		wc_d0 <= beat1 ? bus.dq : wc_d0;                    // [R1]
		wc_m0 <= beat1 ? bus.byte_lane_write_select_n : wc_m0;
	end

	always_ff @(posedge clk_sys) begin
		pend_a  <= beat2 ? wc_a : pend_a;
		pend_d0 <= beat2 ? wc_d0 : pend_d0;
		pend_m0 <= beat2 ? wc_m0 : pend_m0;
		pend_d1 <= beat2 ? bus.dq : pend_d1;                // [R1]
		pend_m1 <= beat2 ? bus.byte_lane_write_select_n : pend_m1;
	end

	// Array update one positive edge after the second beat
	always_ff @(posedge clk_sys) begin
		if (commit) begin
			mem_even[pend_a] <= lane_merge(mem_even[pend_a], pend_d0, pend_m0); // [R11] [R12]
			mem_odd[pend_a]  <= lane_merge(mem_odd[pend_a], pend_d1, pend_m1);
		end
	end
endmodule

// ==== verification/srb_bus_asserts.sv ====
// Pin-bus checker for the burst-of-two SRAM link.
// Assumes one clock for both ends; sits beside the interface instance.
module srb_bus_asserts
	import srb_pkg::*;
(
	input logic      clk_sys,                  // Clock
	input logic      rst,                      // Reset
	input logic      legacy_mode,              // Legacy timing
	input logic      k_clock,                  // Positive phase
	input logic      k_clock_n,                // Negative phase
	input logic      load_strobe_n,            // Load, low
	input logic      read_write,               // High read
	input srb_lane_t byte_lane_write_select_n, // Lane selects
	input logic      ctl_dq_oe,                // Controller drive
	input logic      dev_dq_oe,                // Device drive
	input srb_word_t dq,                       // Data pins
	input logic      output_valid_flag,        // Read valid
	input logic      echo_clock,               // Echo
	input logic      echo_clock_n              // Echo inverse
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	AST_PHASES: assert property (k_clock_n == !k_clock)
		else $error("clock phases not complementary");
	AST_ECHO: assert property (echo_clock == $past(k_clock) && echo_clock_n == !echo_clock)
		else $error("echo clock lost step");
	AST_VALID: assert property (output_valid_flag == dev_dq_oe)
		else $error("valid flag apart from read data");
	AST_ONE_DRIVER: assert property (!(dev_dq_oe && ctl_dq_oe))
		else $error("both ends drive data");
	AST_LOAD_P: assert property (!load_strobe_n |-> k_clock)
		else $error("load outside positive phase");
	// Legacy drive starts one edge early, so both modes overlap on the later sample
	AST_RD_LAT: assert property (!load_strobe_n && read_write |-> ##4 (dev_dq_oe || !legacy_mode) ##1 dev_dq_oe)
		else $error("read words late");
	AST_WR_BEATS: assert property (!load_strobe_n && !read_write |-> ##2 (ctl_dq_oe && k_clock) ##1 ctl_dq_oe)
		else $error("write beats misplaced");
	AST_SEL_IDLE: assert property (!ctl_dq_oe |-> byte_lane_write_select_n == 2'h3)
		else $error("lane select outside a beat");
	AST_RD2WR_GAP: assert property (!load_strobe_n && read_write |=> (load_strobe_n || read_write) [*5])
		else $error("write loaded too soon after read");
	AST_DQ_IDLE: assert property (!dev_dq_oe && !ctl_dq_oe |-> dq == '0)
		else $error("idle data pins not released");

	cover property (!load_strobe_n && read_write);
	cover property (!load_strobe_n && !read_write);
	cover property (legacy_mode && output_valid_flag);
endmodule

// ==== verification/ddr_burst2_sram_bus_port_tb.sv ====
// Testbench joining controller and device ends over one pin bus.
// Assumes the design package and header are compiled first.
module ddr_burst2_sram_bus_port_tb;
	import srb_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

	logic      clk_sys = 1'b0;
	logic      rst = 1'b1;
	logic      dll_disable_n = 1'b1;
	logic      req_valid = 1'b0;
	logic      req_write = 1'b0;
	srb_addr_t req_addr = '0;
	srb_word_t req_wdata0 = '0;
	srb_word_t req_wdata1 = '0;
	srb_lane_t req_sel_n0 = '0;
	srb_lane_t req_sel_n1 = '0;
	logic      req_ready, wr_blocked, rd_valid, legacy_mode;
	srb_word_t rd_data0, rd_data1;
	int        bad_count = 0;
	int        tests_run = 0;
	int        seed = 33914;
	srb_word_t m0[srb_addr_t];
	srb_word_t m1[srb_addr_t];
	srb_word_t q0[$];
	srb_word_t q1[$];
	srb_addr_t pool[8];

	always #20 clk_sys = ~clk_sys;

	srb_bus_if srb_bus_if_i();
	srb_sram_ctl srb_sram_ctl_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req_write(req_write),
		.req_addr(req_addr), .req_wdata0(req_wdata0), .req_wdata1(req_wdata1), .req_sel_n0(req_sel_n0),
		.req_sel_n1(req_sel_n1), .req_ready(req_ready), .wr_blocked(wr_blocked), .rd_data0(rd_data0),
		.rd_data1(rd_data1), .rd_valid(rd_valid), .bus(srb_bus_if_i));
	srb_sram_dev srb_sram_dev_i (.clk_sys(clk_sys), .rst(rst), .dll_disable_n(dll_disable_n),
		.legacy_mode(legacy_mode), .bus(srb_bus_if_i));
	srb_bus_asserts srb_bus_asserts_i (.clk_sys(clk_sys), .rst(rst), .legacy_mode(legacy_mode),
		.k_clock(srb_bus_if_i.k_clock), .k_clock_n(srb_bus_if_i.k_clock_n),
		.load_strobe_n(srb_bus_if_i.load_strobe_n), .read_write(srb_bus_if_i.read_write),
		.byte_lane_write_select_n(srb_bus_if_i.byte_lane_write_select_n), .ctl_dq_oe(srb_bus_if_i.ctl_dq_oe),
		.dev_dq_oe(srb_bus_if_i.dev_dq_oe), .dq(srb_bus_if_i.dq), .output_valid_flag(srb_bus_if_i.output_valid_flag),
		.echo_clock(srb_bus_if_i.echo_clock), .echo_clock_n(srb_bus_if_i.echo_clock_n));

	task automatic check(string name, logic [35:0] seen, logic [35:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic end_of_test();
		$display("Checks %0d, mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	function automatic srb_word_t merge(srb_word_t o, srb_word_t n, srb_lane_t s);
		merge = o;
		for (int l = 0; l < `SRB_LANES; l++) begin
			if (!s[l]) begin
				merge[l*`SRB_LANE_W +: `SRB_LANE_W] = n[l*`SRB_LANE_W +: `SRB_LANE_W];
			end
		end
	endfunction

	// Model updates at the take edge; bursts complete in take order
	task automatic issue(logic w, srb_addr_t a, srb_word_t d0, srb_word_t d1, srb_lane_t s0, srb_lane_t s1);
		int n;
		n = 0;
		req_valid = 1'b1;
		req_write = w;
		req_addr = a;
		req_wdata0 = d0;
		req_wdata1 = d1;
		req_sel_n0 = s0;
		req_sel_n1 = s1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (!(req_ready === 1'b1 && !(w && wr_blocked === 1'b1)) && n < 40);
		check("req_taken", n < 40, 1);
		if (!m0.exists(a)) begin
			m0[a] = 'x;
			m1[a] = 'x;
		end
		if (w) begin
			m0[a] = merge(m0[a], d0, s0);
			m1[a] = merge(m1[a], d1, s1);
		end else begin
			q0.push_back(m0[a]);
			q1.push_back(m1[a]);
		end
		#1;
		if (!w) begin
			check("wr_blocked", wr_blocked, 1);
		end
	endtask

	task automatic drain();
		int n;
		n = 0;
		req_valid = 1'b0;
		while (q0.size() != 0 && n < 60) begin
			@(posedge clk_sys);
			n++;
		end
		check("reads_returned", q0.size(), 0);
		repeat (4) @(posedge clk_sys);
		#1;
	endtask

	task automatic rand_ops(int count);
		logic [31:0] r;
		for (int i = 0; i < count; i++) begin
			r = $random(seed);
			issue(r[0], pool[r[3:1]], srb_word_t'($random(seed)), srb_word_t'($random(seed)), r[5:4], r[7:6]);
			if (r[10:8] == 3'h0) begin
				req_valid = 1'b0;
				// At least one edge so the strobe never toggles twice in one step
				repeat (1 + r[12:11]) @(posedge clk_sys);
				#1;
			end
		end
	endtask

	always @(posedge clk_sys) begin
		if (rd_valid === 1'b1) begin
			check("read_expected", q0.size() != 0, 1);
			if (q0.size() != 0) begin
				check("rd_data0", rd_data0, q0.pop_front());
				check("rd_data1", rd_data1, q1.pop_front());
			end
		end
	end

	initial begin
		for (int i = 0; i < 8; i++) begin
			pool[i] = srb_addr_t'($random(seed));
		end
		pool[0] = '0;
		pool[1] = '1;
		repeat (5) @(posedge clk_sys);
		#1;
		check("ready_in_reset", req_ready, 0);
		check("dev_oe_in_reset", srb_bus_if_i.dev_dq_oe, 0);
		check("echo_n_in_reset", srb_bus_if_i.echo_clock_n, 1);
		rst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			issue(1'b1, pool[i], srb_word_t'($random(seed)), srb_word_t'($random(seed)), 2'h0, 2'h0);
		end
		issue(1'b1, pool[2], 18'h3ffff, 18'h00000, 2'h1, 2'h2);
		issue(1'b0, pool[2], '0, '0, 2'h3, 2'h3);
		issue(1'b0, pool[3], '0, '0, 2'h3, 2'h3);
		issue(1'b1, pool[3], 18'h15555, 18'h2aaaa, 2'h3, 2'h0);
		issue(1'b0, pool[3], '0, '0, 2'h3, 2'h3);
		drain();
		rand_ops(300);
		drain();
		dll_disable_n = 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check("legacy_mode", legacy_mode, 1);
		rand_ops(100);
		drain();
		end_of_test();
	end

	// Whole run needs under two thousand cycles; the margin covers slow paths
	initial begin
		#(40 * 20000);
		bad_count++;
		end_of_test();
	end
endmodule
